// ---- core/ebm_cfg.svh ----
// constants of the external bus master: timing and encodings
// assumes a single 50 MHz system clock; included by the package and the core
//
// How it works
// - drive 3-bit space code, 7 is control space
// - space codes 1,2,5,6,7 used; 0,3,4 never
// - space code stable while address strobe asserted
// - 24-bit address of first byte, held under strobe
// - address strobe half a clock after start
// - 16-bit bidirectional data, 8 or 16 bits
// - read data captured on cycle's last falling edge
// - writes drive all sixteen data lines
// - write data half a clock after address strobe
// - read data strobe together with address strobe
// - write data strobe one clock after address strobe
// - bus fault ends a cycle as an error
// - bus monitor faults unanswered cycles
// - fault plus stop request gives bus error exception
// - autovector ends interrupt acknowledge only, else ignored
// - selects assert only when all parameters match
// - one shared internal acknowledge generator with wait states
// - select timing follows address strobe or slow peripheral clock; data strobe mode swaps read and write timing
// - port directions cleared to input at reset
// - size outputs give bytes left, 00 four
// - direction changes only at cycle start when reversing
`ifndef EBM_CFG_SVH
`define EBM_CFG_SVH

`define EBM_CLK_MHZ 50
`define EBM_BMON_NS 1280
`define EBM_BMON_CYC ((`EBM_BMON_NS * `EBM_CLK_MHZ) / 1000)
`define EBM_SLOW_PERIPHERAL_CLOCK_DIV 8

`define EBM_SP_RSV0 3'h0
`define EBM_SP_UDATA 3'h1
`define EBM_SP_UPROG 3'h2
`define EBM_SP_RSV3 3'h3
`define EBM_SP_RSV4 3'h4
`define EBM_SP_SDATA 3'h5
`define EBM_SP_SPROG 3'h6
`define EBM_SP_CPU 3'h7
`define EBM_IACK_TYPE 4'hf
`define EBM_SZ_BYTE 2'h1
`define EBM_SZ_WORD 2'h2
`define EBM_SZ_THREE 2'h3
`define EBM_SZ_LONG 2'h0

`endif

// ---- core/ebm_pkg.sv ----
// types of the external bus master
// assumes ebm_cfg.svh sits beside it
`include "ebm_cfg.svh"
package ebm_pkg;
    typedef enum logic [1:0] {EBM_ON_AS, EBM_ON_DS, EBM_ON_SLOW_PERIPHERAL_CLOCK} ebm_strobe_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [2:0] space;
        logic write;
        logic [1:0] size;
        logic [15:0] wdata;
        logic [2:0] ipl;
    } ebm_req_t;
    typedef struct packed {
        logic [15:0] rdata;
        logic fault;
        logic bus_err_exc;
        logic port16;
        logic autovec;
    } ebm_rsp_t;
    typedef struct packed {
        logic en;
        logic [23:0] base;
        logic [23:0] mask;
        logic [7:0] space_en;
        logic read_en;
        logic write_en;
        logic [3:0] size_en;
        logic ipl_any;
        logic [2:0] ipl;
        ebm_strobe_t strobe;
        logic auto_ack;
        logic port16;
        logic [3:0] waits;
    } ebm_cs_cfg_t;
    typedef enum logic [2:0] {ST_IDLE, ST_S0, ST_S1, ST_S2, ST_WAIT, ST_CAPT, ST_END} ebm_state_t;
endpackage

// ---- core/ebm_master.sv ----
// external bus master with chip-select matching and shared acknowledge generator
// assumes a 50 MHz clock; one clock cycle is half a bus clock; pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "ebm_cfg.svh"
module ebm_master #(
    parameter int NCS = 4,
    parameter int BMON_CYC = `EBM_BMON_CYC,
    parameter int SLOW_PERIPHERAL_CLOCK_DIV = `EBM_SLOW_PERIPHERAL_CLOCK_DIV
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic req_valid_i,
    input wire ebm_pkg::ebm_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output ebm_pkg::ebm_rsp_t rsp_o,
    input wire ebm_pkg::ebm_cs_cfg_t [NCS-1:0] cs_cfg_i,
    input wire logic halt_req_n_i,
    input wire logic ddr_load_i,
    input wire logic [7:0] ddr_value_i,
    output logic [7:0] port_dir_o,
    output logic boot_port16_o,
    output logic [23:0] addr_o,
    output logic [2:0] space_code_o,
    output logic transfer_size_hi_o,
    output logic transfer_size_lo_o,
    output logic rw_o,
    output logic address_strobe_n_o,
    output logic data_strobe_n_o,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    input wire logic transfer_ack_hi_n_i,
    input wire logic transfer_ack_lo_n_i,
    input wire logic bus_fault_n_i,
    input wire logic auto_vector_request_n_i,
    output logic [NCS-1:0] cs_n_o,
    output logic slow_peripheral_clock_o
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [20:0] pin_s1_q;
    logic [20:0] pin_s2_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // preset to ones by arst_n_i; the strap bit is sampled while the internal reset is still held
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_q <= {21{1'b1}};
            pin_s2_q <= {21{1'b1}};
        end else begin
            pin_s1_q <= {halt_req_n_i, auto_vector_request_n_i, bus_fault_n_i,
                         transfer_ack_hi_n_i, transfer_ack_lo_n_i, data_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire [15:0] data_s = pin_s2_q[15:0];
    wire ack_lo_s = ~pin_s2_q[16];
    wire ack_hi_s = ~pin_s2_q[17];
    wire fault_s = ~pin_s2_q[18];
    wire auto_vector_request_s = ~pin_s2_q[19];
    wire halt_s = ~pin_s2_q[20];

    ////////////////////////////////////////////////////////////////////////////
    // straps and port directions
    logic strap_done_q;
    logic boot16_q;
    logic [7:0] ddr_q;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            boot16_q <= 1'b1;
            ddr_q <= 8'h00;
        end else begin
            strap_done_q <= 1'b1;
            // bit 0 has been through the synchroniser while reset was held
            if (!strap_done_q) boot16_q <= data_s[0];
            if (ddr_load_i) ddr_q <= ddr_value_i;
        end
    end
    assign port_dir_o = ddr_q;
    assign boot_port16_o = boot16_q;

    ////////////////////////////////////////////////////////////////////////////
    // slow peripheral clock divider
    logic [7:0] slow_peripheral_clock_cnt_q;
    logic slow_peripheral_clock_q;
    wire slow_peripheral_clock_wrap = (slow_peripheral_clock_cnt_q == 8'(SLOW_PERIPHERAL_CLOCK_DIV / 2 - 1));
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            slow_peripheral_clock_cnt_q <= 8'h00;
            slow_peripheral_clock_q <= 1'b0;
        end else begin
            slow_peripheral_clock_cnt_q <= slow_peripheral_clock_wrap ? 8'h00 : slow_peripheral_clock_cnt_q + 8'h01;
            if (slow_peripheral_clock_wrap) slow_peripheral_clock_q <= ~slow_peripheral_clock_q;
        end
    end
    assign slow_peripheral_clock_o = slow_peripheral_clock_q;

    ////////////////////////////////////////////////////////////////////////////
    // cycle state
    ebm_pkg::ebm_state_t st_q;
    ebm_pkg::ebm_req_t cur_q;
    logic as_n_q, ds_n_q, oe_q, rw_q, ready_q, rv_q;
    ebm_pkg::ebm_rsp_t rsp_q;
    logic [15:0] bmon_q;
    logic [3:0] wcnt_q;
    logic [NCS-1:0] hit_q, csn_q;

    // interrupt acknowledge is a control-space cycle of the acknowledge type
    wire is_iack = (cur_q.space == `EBM_SP_CPU) && (cur_q.addr[19:16] == `EBM_IACK_TYPE);

    ////////////////////////////////////////////////////////////////////////////
    // chip-select match, one comparator per channel
    logic [NCS-1:0] hit_d, want_n;
    genvar g;
    generate
        for (g = 0; g < NCS; g++) begin : g_cs
            wire ebm_pkg::ebm_cs_cfg_t c = cs_cfg_i[g];
            wire a_ok = (((req_i.addr ^ c.base) & c.mask) == 24'h00_0000);
            wire s_ok = c.space_en[req_i.space];
            wire t_ok = req_i.write ? c.write_en : c.read_en;
            wire z_ok = c.size_en[req_i.size];
            wire i_ok = !((req_i.space == `EBM_SP_CPU)
                          && (req_i.addr[19:16] == `EBM_IACK_TYPE))
                        || c.ipl_any || (c.ipl == req_i.ipl);
            assign hit_d[g] = c.en & a_ok & s_ok & t_ok & z_ok & i_ok;
            // select follows the next address strobe state or the slow clock; data strobe mode uses write strobe timing for reads and read timing for writes
            assign want_n[g] = !(hit_q[g] && (
                (c.strobe == ebm_pkg::EBM_ON_AS && st_q inside {ebm_pkg::ST_S0,
                    ebm_pkg::ST_S1, ebm_pkg::ST_S2, ebm_pkg::ST_WAIT}) ||
                (c.strobe == ebm_pkg::EBM_ON_DS && ((!rw_q && st_q != ebm_pkg::ST_CAPT
                    && st_q != ebm_pkg::ST_END && st_q != ebm_pkg::ST_IDLE) ||
                    (st_q inside {ebm_pkg::ST_S2, ebm_pkg::ST_WAIT}))) ||
                (c.strobe == ebm_pkg::EBM_ON_SLOW_PERIPHERAL_CLOCK && slow_peripheral_clock_q && !as_n_q)));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // shared internal acknowledge generator: lowest matching channel wins
    logic gen_on;
    logic gen_p16;
    logic [3:0] gen_waits;
    always_comb begin
        gen_on = 1'b0;
        gen_p16 = 1'b0;
        gen_waits = 4'h0;
        for (int i = NCS - 1; i >= 0; i--) begin
            if (hit_q[i] && cs_cfg_i[i].auto_ack) begin
                gen_on = 1'b1;
                gen_p16 = (i == 0) ? boot16_q : cs_cfg_i[i].port16;
                gen_waits = cs_cfg_i[i].waits;
            end
        end
    end
    wire int_ack = gen_on && (wcnt_q >= gen_waits);

    // termination decode
    wire ext_ack = ack_hi_s | ack_lo_s;
    wire auto_vector_request_hit = auto_vector_request_s && is_iack;
    wire bmon_hit = (bmon_q >= 16'(BMON_CYC));
    wire fault_end = fault_s | bmon_hit;
    wire term = ext_ack | int_ack | auto_vector_request_hit | fault_end;

    ebm_pkg::ebm_rsp_t rsp_d;
    always_comb begin
        rsp_d.rdata = rw_q ? data_s : 16'h0000;
        rsp_d.fault = fault_end;
        rsp_d.bus_err_exc = fault_end & halt_s;
        rsp_d.port16 = gen_on ? gen_p16 : ack_hi_s;
        rsp_d.autovec = auto_vector_request_hit & ~fault_end;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: S0, S1, S2, CAPT and END each last half a bus clock
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ebm_pkg::ST_IDLE;
            cur_q <= '0;
            as_n_q <= 1'b1;
            ds_n_q <= 1'b1;
            oe_q <= 1'b0;
            rw_q <= 1'b1;
            ready_q <= 1'b0;
            rv_q <= 1'b0;
            rsp_q <= '0;
            bmon_q <= 16'h0000;
            wcnt_q <= 4'h0;
            hit_q <= '0;
        end else begin
            rv_q <= 1'b0;
            unique case (st_q)
                ebm_pkg::ST_IDLE: begin
                    ready_q <= strap_done_q;
                    if (req_valid_i && ready_q) begin
                        cur_q <= req_i;
                        rw_q <= ~req_i.write;
                        hit_q <= hit_d;
                        ready_q <= 1'b0;
                        st_q <= ebm_pkg::ST_S0;
                    end
                end
                ebm_pkg::ST_S0: begin
                    as_n_q <= 1'b0;
                    if (rw_q) ds_n_q <= 1'b0;
                    bmon_q <= 16'h0000;
                    wcnt_q <= 4'h0;
                    st_q <= ebm_pkg::ST_S1;
                end
                ebm_pkg::ST_S1: begin
                    if (!rw_q) oe_q <= 1'b1;
                    st_q <= ebm_pkg::ST_S2;
                end
                ebm_pkg::ST_S2: begin
                    if (!rw_q) ds_n_q <= 1'b0;
                    st_q <= ebm_pkg::ST_WAIT;
                end
                ebm_pkg::ST_WAIT: begin
                    bmon_q <= bmon_q + 16'h0001;
                    if (wcnt_q != 4'hf) wcnt_q <= wcnt_q + 4'h1;
                    if (term) st_q <= ebm_pkg::ST_CAPT;
                end
                ebm_pkg::ST_CAPT: begin
                    rsp_q <= rsp_d;
                    rv_q <= 1'b1;
                    as_n_q <= 1'b1;
                    ds_n_q <= 1'b1;
                    hit_q <= '0;
                    st_q <= ebm_pkg::ST_END;
                end
                ebm_pkg::ST_END: begin
                    oe_q <= 1'b0;
                    ready_q <= 1'b1;
                    st_q <= ebm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) csn_q <= {NCS{1'b1}};
        else csn_q <= want_n;
    end

    assign req_ready_o = ready_q;
    assign rsp_valid_o = rv_q;
    assign rsp_o = rsp_q;
    assign addr_o = cur_q.addr;
    assign space_code_o = cur_q.space;
    assign transfer_size_hi_o = cur_q.size[1];
    assign transfer_size_lo_o = cur_q.size[0];
    assign rw_o = rw_q;
    assign address_strobe_n_o = as_n_q;
    assign data_strobe_n_o = ds_n_q;
    assign data_o = cur_q.wdata;
    assign data_oe_o = oe_q;
    assign cs_n_o = csn_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_space_stable;
        @(posedge clk_i) disable iff (!rst_n)
        (!as_n_q && $past(!as_n_q)) |-> $stable(space_code_o) && $stable(addr_o);
    endproperty
    a_space_stable: assert property (p_space_stable) else $error("space or address moved");

    property p_space_legal;
        @(posedge clk_i) disable iff (!rst_n)
        !as_n_q |-> !(space_code_o inside {`EBM_SP_RSV0, `EBM_SP_RSV3, `EBM_SP_RSV4});
    endproperty
    a_space_legal: assert property (p_space_legal) else $error("reserved space used");

    property p_as_half;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ebm_pkg::ST_S0) |=> !as_n_q && $past(as_n_q);
    endproperty
    a_as_half: assert property (p_as_half) else $error("strobe not half clock late");

    property p_rd_ds;
        @(posedge clk_i) disable iff (!rst_n)
        ($fell(as_n_q) && rw_q) |-> $fell(ds_n_q);
    endproperty
    a_rd_ds: assert property (p_rd_ds) else $error("read data strobe late");

    property p_wr_ds;
        @(posedge clk_i) disable iff (!rst_n)
        ($fell(as_n_q) && !rw_q) |-> ds_n_q ##1 (ds_n_q && oe_q) ##1 !ds_n_q;
    endproperty
    a_wr_ds: assert property (p_wr_ds) else $error("write strobe timing wrong");

    property p_rw_hold;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q != ebm_pkg::ST_IDLE) |=> $stable(rw_o) || $past(st_q == ebm_pkg::ST_IDLE);
    endproperty
    a_rw_hold: assert property (p_rw_hold) else $error("direction changed mid cycle");

    property p_bmon;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ebm_pkg::ST_WAIT && bmon_hit) |=> (st_q == ebm_pkg::ST_CAPT) ##1 (rv_q && rsp_o.fault);
    endproperty
    a_bmon: assert property (p_bmon) else $error("monitor timeout not faulted");

    property p_auto_vector_request_other;
        @(posedge clk_i) disable iff (!rst_n)
        rsp_valid_o |-> !rsp_o.autovec || $past(is_iack, 2);
    endproperty
    a_auto_vector_request_other: assert property (p_auto_vector_request_other) else $error("autovector outside acknowledge");

    property p_cs_match;
        @(posedge clk_i) disable iff (!rst_n)
        (st_q == ebm_pkg::ST_IDLE) |-> cs_n_o == {NCS{1'b1}} || $past(st_q != ebm_pkg::ST_IDLE);
    endproperty
    a_cs_match: assert property (p_cs_match) else $error("select outside a cycle");

    property p_ddr_reset;
        @(posedge clk_i) disable iff (!rst_n)
        !strap_done_q |-> port_dir_o == 8'h00;
    endproperty
    a_ddr_reset: assert property (p_ddr_reset) else $error("port not input after reset");
endmodule // ebm_master
`default_nettype wire

// ---- tb/ebm_responder.sv ----
// memory or peripheral at the far side of the external bus
// assumes the bench muxes the shared data lines from both drive enables
`timescale 1ns/100ps
`default_nettype none
module ebm_responder (
    input wire logic clk_i,
    input wire logic as_n_i,
    input wire logic ds_n_i,
    input wire logic rw_i,
    input wire logic [2:0] mode_i,
    input wire logic [3:0] delay_i,
    input wire logic auto_vector_request_i,
    input wire logic [15:0] rdata_i,
    output logic ack_hi_n_o,
    output logic ack_lo_n_o,
    output logic fault_n_o,
    output logic auto_vector_request_n_o,
    output logic [15:0] data_o,
    output logic data_oe_o
);
    // mode: 0 silent, 1 ack 16-bit, 2 ack 8-bit, 3 fault, 4 fault with ack
    logic [3:0] cnt_q;
    initial begin
        {ack_hi_n_o, ack_lo_n_o, fault_n_o, auto_vector_request_n_o} = 4'hf;
        {data_o, data_oe_o, cnt_q} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // terminations stay asserted until the strobe goes away, as a real port
    always @(negedge clk_i) begin
        data_oe_o <= !as_n_i && !ds_n_i && rw_i;
        data_o <= rdata_i;
        if (as_n_i) begin
            cnt_q <= '0;
            {ack_hi_n_o, ack_lo_n_o, fault_n_o, auto_vector_request_n_o} <= 4'hf;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == delay_i) begin
                ack_hi_n_o <= !(mode_i == 3'h1 || mode_i == 3'h4);
                ack_lo_n_o <= !(mode_i == 3'h2);
                fault_n_o <= !(mode_i >= 3'h3);
                auto_vector_request_n_o <= !auto_vector_request_i;
            end
        end
    end
endmodule // ebm_responder
`default_nettype wire

// ---- tb/tb_external_bus_master.sv ----
// self-checking bench of the external bus master
// assumes the core files compile first; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
`include "ebm_cfg.svh"
module tb_external_bus_master;
    logic clk_i = 1'b0, arst_n_i = 1'b0, req_valid_i = 1'b0, halt_req_n_i = 1'b1;
    logic ddr_load_i = 1'b0, auto_vector_request = 1'b0, strap = 1'b1;
    logic [7:0] ddr_value_i = 8'h00;
    logic [2:0] mode = 3'h0;
    logic [15:0] rdat = 16'h0000, flt = 16'h0001;
    ebm_pkg::ebm_req_t req_i = '0;
    ebm_pkg::ebm_cs_cfg_t [3:0] cs_cfg = '0;
    wire ebm_pkg::ebm_rsp_t rsp_o;
    wire logic req_ready_o, rsp_valid_o, boot_port16_o, rw_o, as_n, ds_n, data_oe_o, rs_oe;
    wire logic sz_hi, sz_lo, ack_hi_n, ack_lo_n, fault_n, auto_vector_request_n;
    wire logic [7:0] port_dir_o;
    wire logic [23:0] addr_o;
    wire logic [2:0] space_code_o;
    wire logic [15:0] data_o, rs_d, data_i;
    wire logic [3:0] cs_n_o;
    int fails = 0, n_checks = 0, as_cnt, ds_at, oe_at;
    logic [3:0] cs_seen;
    logic [23:0] ad_s;
    logic [15:0] wd_s;
    logic [2:0] sp_s;
    logic [1:0] sz_s;
    logic rw_s;
    // released lines keep toggling so a stale value cannot pass for data
    assign data_i = rs_oe ? rs_d : (data_oe_o ? data_o : flt);
    always #10 clk_i = ~clk_i;
    ebm_master #(.NCS(4), .BMON_CYC(8), .SLOW_PERIPHERAL_CLOCK_DIV(8)) i_dut (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
        .cs_cfg_i(cs_cfg), .halt_req_n_i(halt_req_n_i), .ddr_load_i(ddr_load_i),
        .ddr_value_i(ddr_value_i), .port_dir_o(port_dir_o), .boot_port16_o(boot_port16_o),
        .addr_o(addr_o), .space_code_o(space_code_o), .transfer_size_hi_o(sz_hi),
        .transfer_size_lo_o(sz_lo), .rw_o(rw_o), .address_strobe_n_o(as_n),
        .data_strobe_n_o(ds_n), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
        .transfer_ack_hi_n_i(ack_hi_n), .transfer_ack_lo_n_i(ack_lo_n),
        .bus_fault_n_i(fault_n), .auto_vector_request_n_i(auto_vector_request_n), .cs_n_o(cs_n_o),
        .slow_peripheral_clock_o());
    ebm_responder i_resp (.clk_i(clk_i), .as_n_i(as_n), .ds_n_i(ds_n), .rw_i(rw_o),
        .mode_i(mode), .delay_i(4'h2), .auto_vector_request_i(auto_vector_request), .rdata_i(rdat),
        .ack_hi_n_o(ack_hi_n), .ack_lo_n_o(ack_lo_n), .fault_n_o(fault_n),
        .auto_vector_request_n_o(auto_vector_request_n), .data_o(rs_d), .data_oe_o(rs_oe));
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        if (!strap) flt <= ~flt;
        if (!as_n) begin
            as_cnt <= as_cnt + 1;
            {ad_s, sp_s, sz_s, rw_s} <= {addr_o, space_code_o, sz_hi, sz_lo, rw_o};
            if (!ds_n && ds_at == 15) ds_at <= as_cnt;
            if (!ds_n) wd_s <= data_o;
            if (data_oe_o && oe_at == 15) oe_at <= as_cnt;
            cs_seen <= cs_seen | ~cs_n_o;
        end
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one bus cycle from request to response; partner behaviour set by md
    task automatic xfer(input logic [23:0] a, input logic [2:0] sp, input logic wr,
        input logic [1:0] sz, input logic [15:0] wd, input logic [2:0] md);
        int k;
        k = 0;
        {as_cnt, ds_at, oe_at, cs_seen} = {32'd0, 32'd15, 32'd15, 4'h0};
        req_i = '{addr: a, space: sp, write: wr, size: sz, wdata: wd, ipl: 3'h0};
        mode = md;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && k < 50) begin
            @(negedge clk_i);
            k++;
        end
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && k < 300) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 300) chk("response", 24'h0, 24'h1);
        @(negedge clk_i);
        chk("space", {21'h0, sp_s}, {21'h0, sp});
        chk("addr", ad_s, a);
        chk("size", {22'h0, sz_s}, {22'h0, sz});
        chk("dir", {23'h0, rw_s}, {23'h0, !wr});
        chk("ds_offset", as_cnt > 0 ? ds_at : 0, as_cnt > 0 ? (wr ? 2 : 0) : 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge clk_i);
        fails++;
        stop_test();
    end
    initial begin
        cs_cfg[1] = '{en: 1'b1, base: 24'h80_0000, mask: 24'hff_f000, space_en: 8'hff,
            read_en: 1'b1, write_en: 1'b1, size_en: 4'hf, ipl_any: 1'b1, ipl: 3'h0,
            strobe: ebm_pkg::EBM_ON_AS, auto_ack: 1'b1, port16: 1'b0, waits: 4'h2};
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
        strap = 1'b0;
        chk("port_dir_rst", {16'h0, port_dir_o}, 24'h0);
        chk("boot16", {23'h0, boot_port16_o}, 24'h1);
        ddr_value_i = 8'ha5;
        ddr_load_i = 1'b1;
        @(negedge clk_i);
        ddr_load_i = 1'b0;
        @(negedge clk_i);
        chk("port_dir", {16'h0, port_dir_o}, 24'ha5);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rdat = 16'h1234 + 16'(i * 16'h1111);
            xfer(24'h01_2340 + 24'(i), 3'(i < 2 ? i + 1 : i + 3), 1'b0, 2'(i), 16'h0, 3'h1);
            chk("rdata", {8'h0, rsp_o.rdata}, {8'h0, rdat});
            chk("port16", {23'h0, rsp_o.port16}, 24'h1);
        end
        $display("test reads done");
        for (int i = 0; i < 2; i++) begin
            xfer(24'h00_4000, `EBM_SP_SDATA, 1'b1, 2'h2, 16'hbeef ^ 16'(i), 3'h2);
            chk("wdata", {8'h0, wd_s}, {8'h0, 16'hbeef ^ 16'(i)});
            chk("oe_offset", 24'(oe_at), 24'h1);
            chk("port8", {23'h0, rsp_o.port16}, 24'h0);
        end
        $display("test writes done");
        xfer(24'h00_0100, `EBM_SP_UDATA, 1'b0, 2'h1, 16'h0, 3'h3);
        chk("fault", {22'h0, rsp_o.fault, rsp_o.bus_err_exc}, 24'h2);
        halt_req_n_i = 1'b0;
        xfer(24'h00_0102, `EBM_SP_UDATA, 1'b1, 2'h1, 16'h0055, 3'h4);
        halt_req_n_i = 1'b1;
        chk("bus_err", {22'h0, rsp_o.fault, rsp_o.bus_err_exc}, 24'h3);
        xfer(24'h00_0104, `EBM_SP_UPROG, 1'b0, 2'h2, 16'h0, 3'h0);
        chk("monitor", {23'h0, rsp_o.fault}, 24'h1);
        $display("test faults done");
        auto_vector_request = 1'b1;
        xfer(24'hff_fff3, `EBM_SP_CPU, 1'b0, 2'h1, 16'h0, 3'h0);
        chk("autovec", {22'h0, rsp_o.autovec, rsp_o.fault}, 24'h2);
        xfer(24'h00_0200, `EBM_SP_UDATA, 1'b0, 2'h2, 16'h0, 3'h1);
        chk("no_auto_vector_request", {23'h0, rsp_o.autovec}, 24'h0);
        auto_vector_request = 1'b0;
        $display("test autovector done");
        xfer(24'h80_0010, `EBM_SP_SDATA, 1'b0, 2'h2, 16'h0, 3'h0);
        chk("cs_hit", {20'h0, cs_seen}, 24'h2);
        chk("int_ack", {22'h0, rsp_o.fault, rsp_o.port16}, 24'h0);
        xfer(24'h81_0010, `EBM_SP_SDATA, 1'b0, 2'h2, 16'h0, 3'h1);
        chk("cs_miss", {20'h0, cs_seen}, 24'h0);
        $display("test selects done");
        // second reset with the strap line low: boot select must come up 8-bit
        strap = 1'b1;
        @(negedge clk_i);
        flt = 16'h0000;
        arst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
        chk("boot8", {23'h0, boot_port16_o}, 24'h0);
        chk("port_dir_rst2", {16'h0, port_dir_o}, 24'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule // tb_external_bus_master
`default_nettype wire
